//--- bench/gcc_host_model.sv
// host model: serial management master
// assumes the bench calls frame(); shift clock parks low between frames
`timescale 1ns/1ps
module gcc_host_model
    import gcc_pkg::*;
(
    output logic      cs_n_pin,
    output logic      shift_clk_pin,
    output logic      serial_in_pin,
    input wire logic  serial_out_pin,
    input wire logic  serial_out_oe_n
);
    // idle: deselected, clock low
    initial begin
        cs_n_pin = 1'b1;
        shift_clk_pin = 1'b0;
        serial_in_pin = 1'b0;
    end
    // read flag, address, data; fewer than 24 bits aborts the frame
    task automatic frame(input logic rd, input logic [14:0] a, input logic [7:0] d,
                         input int nb, output logic [7:0] q);
        logic [23:0] bits;
        bits = {rd, a, d};
        q = 8'h00;
        cs_n_pin = 1'b0;
        for (int i = 23; i > 23 - nb; i--) begin
            serial_in_pin = bits[i];
            #62.5 shift_clk_pin = 1'b1;
            q[i % 8] = serial_out_oe_n ? 1'bx : serial_out_pin;
            #62.5 shift_clk_pin = 1'b0;
        end
        #62.5 cs_n_pin = 1'b1;
        serial_in_pin = ~serial_in_pin; // no stale bit after release
        #250;
    endtask
endmodule

//--- bench/gcc_top_monitor.sv
// checker for the clock and control pins block
// assumes binding to gcc_top, one clock domain
`timescale 1ns/1ps
module gcc_top_monitor
    import gcc_pkg::*;
(
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic [3:0]  master_rate_strap,
    input wire logic [3:0]  clock_gen_reg,
    input wire logic        t1_rate_clock_oe_n,
    input wire logic        e1_rate_clock_oe_n,
    input wire logic [3:0]  strap_multiplier,
    input wire logic        strap_base_e1,
    input wire logic        rx_term_control_pin,
    input wire logic [15:0] rx_term_external,
    input wire logic        line_oe_pin,
    input wire logic        line_drivers_enable,
    input wire logic        line_mode_pin_enable,
    input wire logic        line_mode_pin,
    input wire logic [15:0] channel_rate_bit,
    input wire logic [15:0] channel_is_e1,
    input wire logic [3:0]  gp_reg_wr,
    input wire logic [1:0]  gp_pin_oe_n,
    input wire logic        dev_reset_busy,
    input wire logic        int_pending,
    input wire logic [3:0]  global_config_reg,
    input wire logic        int_pin_out,
    input wire logic        int_pin_oe_n,
    input wire logic        host_wr_stb,
    input wire logic        host_rd_stb
);
    logic [8:0] busy_cnt_r;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // cycles spent busy since reset release
    always_ff @(posedge ref_clk) begin
        if (!rst_n || !dev_reset_busy)
            busy_cnt_r <= 9'h000;
        else
            busy_cnt_r <= busy_cnt_r + 9'h001;
    end
    property p_strap;
        $stable(master_rate_strap)[*5] |-> strap_base_e1 == master_rate_strap[3]
            && strap_multiplier == {1'b0, master_rate_strap[2:0]} + 4'h1;
    endproperty
    property p_t1_off;
        !clock_gen_reg[1] |=> t1_rate_clock_oe_n;
    endproperty
    property p_e1_off;
        !clock_gen_reg[3] |=> e1_rate_clock_oe_n;
    endproperty
    property p_term;
        !rx_term_control_pin [*5] |-> rx_term_external == 16'hFFFF;
    endproperty
    property p_oe;
        $stable(line_oe_pin)[*5] |-> line_drivers_enable == line_oe_pin;
    endproperty
    property p_mode;
        $stable({line_mode_pin_enable, line_mode_pin, channel_rate_bit})[*5] |->
            channel_is_e1 == (line_mode_pin_enable ? {16{!line_mode_pin}} : channel_rate_bit);
    endproperty
    property p_gp;
        $stable(gp_reg_wr)[*5] |-> gp_pin_oe_n == ~gp_reg_wr[1:0];
    endproperty
    property p_int_pp;
        $past(rst_n, 4) && !global_config_reg[2] |=> !int_pin_oe_n
            && int_pin_out == ($past(int_pending) ~^ $past(global_config_reg[3]));
    endproperty
    property p_int_od;
        global_config_reg[2] && !int_pending |=> int_pin_oe_n;
    endproperty
    property p_busy;
        busy_cnt_r <= 9'd200;
    endproperty
    a_strap: assert property (p_strap) else $error("strap decode wrong");
    a_t1_off: assert property (p_t1_off) else $error("t1 clock driven");
    a_e1_off: assert property (p_e1_off) else $error("e1 clock driven");
    a_term: assert property (p_term) else $error("termination not external");
    a_oe: assert property (p_oe) else $error("driver enable wrong");
    a_mode: assert property (p_mode) else $error("line mode wrong");
    a_gp: assert property (p_gp) else $error("gp direction wrong");
    a_int_pp: assert property (p_int_pp) else $error("push-pull level wrong");
    a_int_od: assert property (p_int_od) else $error("open drain driven");
    a_busy: assert property (p_busy) else $error("reset too long");
    c_wr: cover property (host_wr_stb);
    c_rd: cover property (host_rd_stb);
    c_ready: cover property ($fell(dev_reset_busy));
endmodule
bind gcc_top gcc_top_monitor u_mon (.ref_clk, .rst_n, .master_rate_strap, .clock_gen_reg,
    .t1_rate_clock_oe_n, .e1_rate_clock_oe_n, .strap_multiplier, .strap_base_e1,
    .rx_term_control_pin, .rx_term_external, .line_oe_pin, .line_drivers_enable,
    .line_mode_pin_enable, .line_mode_pin, .channel_rate_bit, .channel_is_e1, .gp_reg_wr,
    .gp_pin_oe_n, .dev_reset_busy, .int_pending, .global_config_reg, .int_pin_out,
    .int_pin_oe_n, .host_wr_stb, .host_rd_stb);

//--- bench/gcc_top_tb.sv
// bench for the clock and control pins block
// assumes the host model on the serial port; registers are plain inputs
`timescale 1ns/1ps
`include "gcc_regs.svh"
module gcc_top_tb
    import gcc_pkg::*;
;
    logic ref_clk = 1'b0, rst_n = 1'b0, line_oe_pin = 1'b1, rx_term_control_pin = 1'b0;
    logic line_mode_pin_enable = 1'b1, line_mode_pin = 1'b1, int_pending = 1'b0;
    logic [3:0] master_rate_strap = 4'h0, clock_gen_reg = 4'h0, gp_reg_wr = 4'h0;
    logic [3:0] global_config_reg = 4'h0;
    logic [15:0] channel_rate_bit = 16'h0000, rx_term_external, rx_partial_internal;
    logic [15:0] channel_is_e1, ref_clock_internal;
    logic [4:0] rx_config0_reg [16] = '{default: 5'h00};
    logic [1:0] rx_term_sel [16], gp_pin_in = 2'b00, gp_level_rd, gp_pin_out, gp_pin_oe_n;
    logic [7:0] host_rdata = 8'h9B, host_wdata, rq, cap_data;
    logic [14:0] host_addr, cap_addr;
    logic [3:0] strap_multiplier;
    logic t1_rate_clock_out, t1_rate_clock_oe_n, e1_rate_clock_out, e1_rate_clock_oe_n;
    logic strap_base_e1, line_drivers_enable, dev_reset_busy, int_pin_out, int_pin_oe_n;
    logic cs_n_pin, shift_clk_pin, serial_in_pin, serial_out_pin, serial_out_oe_n;
    logic host_wr_stb, host_rd_stb, wr_d = 1'b0, rd_d = 1'b0, drv;
    int n_mismatch = 0, n_checks = 0, wr_seen = 0, rd_seen = 0, cnt [4];
    gcc_top u_dut (
        .ref_clk, .rst_n, .master_rate_strap, .clock_gen_reg, .t1_rate_clock_out,
        .t1_rate_clock_oe_n, .e1_rate_clock_out, .e1_rate_clock_oe_n, .strap_multiplier,
        .strap_base_e1, .rx_term_control_pin, .rx_config0_reg, .rx_term_external,
        .rx_partial_internal, .rx_term_sel, .line_oe_pin, .line_drivers_enable,
        .line_mode_pin_enable, .line_mode_pin, .channel_rate_bit, .channel_is_e1,
        .ref_clock_internal, .gp_reg_wr, .gp_level_rd, .gp_pin_in, .gp_pin_out, .gp_pin_oe_n,
        .dev_reset_busy, .int_pending, .global_config_reg, .int_pin_out, .int_pin_oe_n,
        .cs_n_pin, .shift_clk_pin, .serial_in_pin, .serial_out_pin, .serial_out_oe_n,
        .host_wr_stb, .host_rd_stb, .host_addr, .host_wdata, .host_rdata);
    gcc_host_model u_host (.cs_n_pin, .shift_clk_pin, .serial_in_pin, .serial_out_pin,
        .serial_out_oe_n);
    always #5 ref_clk = ~ref_clk;
    // host strobes; address and data settle the cycle after
    always @(posedge ref_clk) begin
        wr_d <= host_wr_stb;
        rd_d <= host_rd_stb;
        wr_seen <= wr_seen + int'(wr_d);
        rd_seen <= rd_seen + int'(rd_d);
        if (wr_d || rd_d) cap_addr <= host_addr;
        if (wr_d) cap_data <= host_wdata;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic wrap_up();
        if (n_mismatch == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    function automatic logic [3:0] clks();
        clks = {t1_rate_clock_out, e1_rate_clock_out,
                ref_clock_internal[0], ref_clock_internal[2]};
    endfunction
    // rising edges of the four clocks over n cycles
    task automatic count_edges(input int n);
        logic [3:0] prev, cur;
        prev = clks();
        cnt = '{default: 0};
        repeat (n) begin
            step(1);
            cur = clks();
            for (int k = 0; k < 4; k++) cnt[k] += int'(cur[k] & !prev[k]);
            prev = cur;
        end
    endtask
    task automatic chk_rate(input int k, input real hz, input int n);
        int lo;
        lo = int'($floor(hz * n * 1.0e-8));
        chk(16'(cnt[k] >= lo && cnt[k] <= lo + 1), 16'h0001);
    endtask
    task automatic wait_ready();
        int i;
        i = 0;
        while (dev_reset_busy !== 1'b0 && i < 400) begin
            step(1);
            i++;
        end
        chk(16'(i <= `GCC_RST_CYC + 1), 16'h0001);
    endtask
    // main sequence
    initial begin
        step(2);
        rst_n = 1'b1;
        wait_ready();
        for (int s = 0; s < 16; s++) begin
            master_rate_strap = 4'(s);
            step(5);
            chk({11'h000, strap_base_e1, strap_multiplier},
                {11'h000, s[3], 4'(s % 8 + 1)});
        end
        line_mode_pin_enable = 1'b0;
        channel_rate_bit = 16'h0001;
        for (int c = 0; c < 4; c++) begin
            clock_gen_reg = {c[1], 1'b0, c[0], 1'b0};
            step(3);
            chk(16'({t1_rate_clock_oe_n, e1_rate_clock_oe_n}), 16'({!c[0], !c[1]}));
        end
        clock_gen_reg = 4'hF;
        step(20);
        count_edges(2000);
        chk_rate(3, `GCC_T1_HZ, 2000);
        chk_rate(2, `GCC_E1_HZ, 2000);
        chk_rate(1, `GCC_E1_HZ, 2000);
        chk_rate(0, `GCC_T1_HZ, 2000);
        clock_gen_reg = 4'hA;
        step(20);
        count_edges(26000);
        chk_rate(3, `GCC_F8K_HZ, 26000);
        chk_rate(2, `GCC_F8K_HZ, 26000);
        for (int c = 0; c < 16; c++) rx_config0_reg[c] = 5'(c * 7);
        step(5);
        chk(rx_term_external, 16'hFFFF);
        chk(rx_partial_internal, 16'h0000);
        rx_term_control_pin = 1'b1;
        step(5);
        for (int c = 0; c < 16; c++) begin
            chk(16'(rx_term_external[c]), 16'(rx_config0_reg[c][2]));
            if (!rx_config0_reg[c][2])
                chk(16'({rx_partial_internal[c], rx_term_sel[c]}), 16'({rx_config0_reg[c][4],
                    rx_config0_reg[c][1:0]}));
        end
        for (int v = 0; v < 2; v++) begin
            line_oe_pin = v[0];
            step(5);
            chk(16'(line_drivers_enable), 16'(v));
        end
        channel_rate_bit = 16'hA5C3;
        for (int m = 0; m < 3; m++) begin
            line_mode_pin_enable = (m != 0);
            line_mode_pin = (m == 2);
            step(5);
            chk(channel_is_e1, m == 0 ? 16'hA5C3 : m == 1 ? 16'hFFFF : 16'h0000);
        end
        gp_pin_in = 2'b10;
        gp_reg_wr = 4'b0001;
        step(5);
        chk(16'({gp_pin_oe_n, gp_pin_out[0], gp_level_rd[1]}), 16'h0009);
        gp_pin_in = 2'b01;
        gp_reg_wr = 4'b1010;
        step(5);
        chk(16'({gp_pin_oe_n, gp_pin_out[1], gp_level_rd[0]}), 16'h0007);
        for (int g = 0; g < 8; g++) begin
            global_config_reg = {g[1], g[0], 2'b00};
            int_pending = g[2];
            drv = !g[0] || g[2];
            step(2);
            chk(16'(int_pin_oe_n), 16'(!drv));
            if (drv) chk(16'(int_pin_out), 16'(g[2] ? g[1] : !g[1]));
        end
        u_host.frame(1'b0, 15'h5A3C, 8'hC6, 24, rq);
        step(5);
        chk(16'({wr_seen[3:0], cap_data}), 16'h01C6);
        chk(16'(cap_addr), 16'h5A3C);
        u_host.frame(1'b0, 15'h1111, 8'h22, 10, rq);
        step(5);
        chk(16'(wr_seen + rd_seen), 16'h0001);
        u_host.frame(1'b1, 15'h0F0F, 8'h00, 24, rq);
        step(5);
        chk(16'({rd_seen[3:0], rq}), 16'h019B);
        chk(16'(cap_addr), 16'h0F0F);
        rst_n = 1'b0;
        step(2);
        chk(16'({t1_rate_clock_oe_n, e1_rate_clock_oe_n, int_pin_oe_n, gp_pin_oe_n,
            dev_reset_busy}), 16'h003F);
        rst_n = 1'b1;
        wait_ready();
        wrap_up();
    end
    // watchdog well beyond the expected run
    initial begin
        #600000;
        n_mismatch++;
        wrap_up();
    end
endmodule

//--- logic/gcc_pkg.sv
// global clock and control pins: shared types
// assumes the constants header is alongside
`include "gcc_regs.svh"
package gcc_pkg;
    typedef enum logic [2:0] {
        GCC_SER_IDLE = 3'h1,
        GCC_SER_ADDR = 3'h2,
        GCC_SER_DATA = 3'h4
    } gcc_ser_t;
    typedef logic [`GCC_PH_W-1:0] gcc_phase_t;
endpackage

//--- logic/gcc_regs.svh
// global clock and control pins: constants for positions, widths and timing
// assumes inclusion by the package and the top module of the block
`ifndef GCC_REGS_SVH
`define GCC_REGS_SVH
`define GCC_CLK_HZ         100000000
`define GCC_RST_MAX_NS     2000
`define GCC_RST_CYC        ((`GCC_RST_MAX_NS * (`GCC_CLK_HZ / 1000000)) / 1000)
`define GCC_STRAP_BASE     3
`define GCC_CG_T1_SEL      0
`define GCC_CG_T1_EN       1
`define GCC_CG_E1_SEL      2
`define GCC_CG_E1_EN       3
`define GCC_TERM_EXT       2
`define GCC_TERM_PART      4
`define GCC_INT_DRV        2
`define GCC_INT_POL        3
`define GCC_GP_LVL         2
`define GCC_NCH            16
`define GCC_PH_W           32
`define GCC_PH_MAX         32'h80000000
`define GCC_T1_HZ          1544000
`define GCC_E1_HZ          2048000
`define GCC_F8K_HZ         8000
`define GCC_SER_AW         15
`define GCC_SER_FRAME      24
`endif

//--- logic/gcc_top.sv
// global clock and control pins: rate straps, reference clocks, mode pins, serial port
// assumes a 100 MHz ref_clk; pins from outside are synchronised here; registers live outside
`timescale 1ns/1ps
`include "gcc_regs.svh"

// Function
// - decode strap: base rate and multiplier
// - t1 clock output only when enabled
// - t1 output 8 KHz or 1.544 MHz
// - e1 clock output only when enabled
// - e1 output 8 KHz or 2.048 MHz
// - termination pin low forces external matching
// - termination pin high follows channel fields
// - output-enable low floats all line drivers
// - mode pin enable low uses channel bit
// - global pin: low E1, open T1
// - gp pins direction from direction bits
// - gp level driven or reflects pin
// - hardware reset completes within 2 us
// - interrupt asserted for unmasked pending source
// - interrupt drive style and level selectable
// - serial input sampled on shift clock rise
// - serial output changes on shift clock fall
// - internal reference 1.544 or 2.048 MHz per mode
module gcc_top
    import gcc_pkg::*;
(
    input  wire logic                   ref_clk,
    input  wire logic                   rst_n,
    input  wire logic [3:0]             master_rate_strap,
    input  wire logic [3:0]             clock_gen_reg,
    output logic                        t1_rate_clock_out,
    output logic                        t1_rate_clock_oe_n,
    output logic                        e1_rate_clock_out,
    output logic                        e1_rate_clock_oe_n,
    output logic [3:0]                  strap_multiplier,
    output logic                        strap_base_e1,
    input  wire logic                   rx_term_control_pin,
    input  wire logic [4:0]             rx_config0_reg [`GCC_NCH],
    output logic [`GCC_NCH-1:0]         rx_term_external,
    output logic [`GCC_NCH-1:0]         rx_partial_internal,
    output logic [1:0]                  rx_term_sel [`GCC_NCH],
    input  wire logic                   line_oe_pin,
    output logic                        line_drivers_enable,
    input  wire logic                   line_mode_pin_enable,
    input  wire logic                   line_mode_pin,
    input  wire logic [`GCC_NCH-1:0]    channel_rate_bit,
    output logic [`GCC_NCH-1:0]         channel_is_e1,
    output logic [`GCC_NCH-1:0]         ref_clock_internal,
    input  wire logic [3:0]             gp_reg_wr,
    output logic [1:0]                  gp_level_rd,
    input  wire logic [1:0]             gp_pin_in,
    output logic [1:0]                  gp_pin_out,
    output logic [1:0]                  gp_pin_oe_n,
    output logic                        dev_reset_busy,
    input  wire logic                   int_pending,
    input  wire logic [3:0]             global_config_reg,
    output logic                        int_pin_out,
    output logic                        int_pin_oe_n,
    input  wire logic                   cs_n_pin,
    input  wire logic                   shift_clk_pin,
    input  wire logic                   serial_in_pin,
    output logic                        serial_out_pin,
    output logic                        serial_out_oe_n,
    output logic                        host_wr_stb,
    output logic                        host_rd_stb,
    output logic [`GCC_SER_AW-1:0]      host_addr,
    output logic [7:0]                  host_wdata,
    input  wire logic [7:0]             host_rdata
);

    // phase increment for a target rate against ref_clk
    function automatic gcc_phase_t gcc_inc(input int unsigned hz);
        longint unsigned p;
        p = (longint'(hz) << `GCC_PH_W) / `GCC_CLK_HZ;
        return p[`GCC_PH_W-1:0];
    endfunction

    localparam gcc_phase_t INC_T1  = gcc_inc(`GCC_T1_HZ);
    localparam gcc_phase_t INC_E1  = gcc_inc(`GCC_E1_HZ);
    localparam gcc_phase_t INC_8K  = gcc_inc(`GCC_F8K_HZ);
    localparam int         RST_CYC = `GCC_RST_CYC;

    // two-flop synchronisers for every pin input
    logic [3:0] strap_s1_r, strap_s2_r;
    logic       term_s1_r, term_s2_r, oe_s1_r, oe_s2_r;
    logic       lme_s1_r, lme_s2_r, lm_s1_r, lm_s2_r;
    logic [1:0] gp_s1_r, gp_s2_r;
    logic       cs_s1_r, cs_s2_r, sck_s1_r, sck_s2_r, sdi_s1_r, sdi_s2_r;
    always_ff @(posedge ref_clk) begin
        strap_s1_r <= master_rate_strap;
        strap_s2_r <= strap_s1_r;
        term_s1_r  <= rx_term_control_pin;
        term_s2_r  <= term_s1_r;
        oe_s1_r    <= line_oe_pin;
        oe_s2_r    <= oe_s1_r;
        lme_s1_r   <= line_mode_pin_enable;
        lme_s2_r   <= lme_s1_r;
        lm_s1_r    <= line_mode_pin;
        lm_s2_r    <= lm_s1_r;
        gp_s1_r    <= gp_pin_in;
        gp_s2_r    <= gp_s1_r;
        cs_s1_r    <= cs_n_pin;
        cs_s2_r    <= cs_s1_r;
        sck_s1_r   <= shift_clk_pin;
        sck_s2_r   <= sck_s1_r;
        sdi_s1_r   <= serial_in_pin;
        sdi_s2_r   <= sdi_s1_r;
    end

    // reset sequencer: busy for a bounded count after reset
    logic [$clog2(RST_CYC+1)-1:0] rst_cnt_r;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rst_cnt_r      <= '0;
            dev_reset_busy <= 1'b1;
        end else begin
            if (rst_cnt_r != RST_CYC[$bits(rst_cnt_r)-1:0]) begin
                rst_cnt_r <= rst_cnt_r + 1'b1;
            end
            dev_reset_busy <= (rst_cnt_r < RST_CYC[$bits(rst_cnt_r)-1:0] - 1'b1);
        end
    end

    // strap decode: top bit base, low bits plus one multiplier
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            strap_base_e1    <= 1'b0;
            strap_multiplier <= 4'h1;
        end else begin
            strap_base_e1    <= strap_s2_r[`GCC_STRAP_BASE];
            strap_multiplier <= {1'b0, strap_s2_r[2:0]} + 4'h1;
        end
    end

    // phase accumulators locked to the master reference
    gcc_phase_t acc_t1_r, acc_e1_r, acc_8k_r;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            acc_t1_r <= '0;
            acc_e1_r <= '0;
            acc_8k_r <= '0;
        end else begin
            acc_t1_r <= acc_t1_r + INC_T1;
            acc_e1_r <= acc_e1_r + INC_E1;
            acc_8k_r <= acc_8k_r + INC_8K;
        end
    end

    // selectable, gateable rate clock outputs
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            t1_rate_clock_out  <= 1'b0;
            t1_rate_clock_oe_n <= 1'b1;
            e1_rate_clock_out  <= 1'b0;
            e1_rate_clock_oe_n <= 1'b1;
        end else begin
            t1_rate_clock_oe_n <= ~clock_gen_reg[`GCC_CG_T1_EN];
            e1_rate_clock_oe_n <= ~clock_gen_reg[`GCC_CG_E1_EN];
            t1_rate_clock_out  <= clock_gen_reg[`GCC_CG_T1_SEL] ?
                                  acc_t1_r[`GCC_PH_W-1] : acc_8k_r[`GCC_PH_W-1];
            e1_rate_clock_out  <= clock_gen_reg[`GCC_CG_E1_SEL] ?
                                  acc_e1_r[`GCC_PH_W-1] : acc_8k_r[`GCC_PH_W-1];
        end
    end

    // per-channel mode and internal reference selection
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            channel_is_e1      <= '0;
            ref_clock_internal <= '0;
        end else begin
            for (int c = 0; c < `GCC_NCH; c++) begin
                if (!lme_s2_r) begin
                    channel_is_e1[c] <= channel_rate_bit[c];
                end else begin
                    channel_is_e1[c] <= ~lm_s2_r;
                end
                ref_clock_internal[c] <= channel_is_e1[c] ?
                                         acc_e1_r[`GCC_PH_W-1] : acc_t1_r[`GCC_PH_W-1];
            end
        end
    end

    // receive termination per channel, overridden by the pin
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rx_term_external    <= '1;
            rx_partial_internal <= '0;
            for (int c = 0; c < `GCC_NCH; c++) begin
                rx_term_sel[c] <= 2'h0;
            end
        end else begin
            for (int c = 0; c < `GCC_NCH; c++) begin
                if (!term_s2_r) begin
                    rx_term_external[c]    <= 1'b1;
                    rx_partial_internal[c] <= 1'b0;
                    rx_term_sel[c]         <= 2'h0;
                end else begin
                    rx_term_external[c]    <= rx_config0_reg[c][`GCC_TERM_EXT];
                    rx_partial_internal[c] <= rx_config0_reg[c][`GCC_TERM_PART];
                    rx_term_sel[c]         <= rx_config0_reg[c][1:0];
                end
            end
        end
    end

    // global line driver enable, no effect on internal state
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            line_drivers_enable <= 1'b0;
        end else begin
            line_drivers_enable <= oe_s2_r;
        end
    end

    // general purpose pins
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            gp_pin_out  <= 2'h0;
            gp_pin_oe_n <= 2'h3;
            gp_level_rd <= 2'h0;
        end else begin
            for (int g = 0; g < 2; g++) begin
                gp_pin_oe_n[g] <= ~gp_reg_wr[g];
                gp_pin_out[g]  <= gp_reg_wr[`GCC_GP_LVL+g];
                gp_level_rd[g] <= gp_reg_wr[g] ? gp_reg_wr[`GCC_GP_LVL+g] : gp_s2_r[g];
            end
        end
    end

    // interrupt pin: polarity and open-drain or push-pull
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            int_pin_out  <= 1'b0;
            int_pin_oe_n <= 1'b1;
        end else begin
            if (global_config_reg[`GCC_INT_DRV]) begin
                int_pin_out  <= global_config_reg[`GCC_INT_POL];
                int_pin_oe_n <= ~int_pending;
            end else begin
                int_pin_out  <= int_pending ~^ global_config_reg[`GCC_INT_POL];
                int_pin_oe_n <= 1'b0;
            end
        end
    end

    // serial host port edge detection on the synchronised pins
    logic sck_d_r, cs_d_r;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sck_d_r <= 1'b0;
            cs_d_r  <= 1'b1;
        end else begin
            sck_d_r <= sck_s2_r;
            cs_d_r  <= cs_s2_r;
        end
    end
    logic sck_rise, sck_fall, cs_fall;
    assign sck_rise = sck_s2_r & ~sck_d_r;
    assign sck_fall = ~sck_s2_r & sck_d_r;
    assign cs_fall  = ~cs_s2_r & cs_d_r;

    // serial frame engine: r/w bit, address msb first, data byte
    gcc_ser_t                   ser_st_r;
    logic [4:0]                 bit_cnt_r;
    logic                       rd_r;
    logic [`GCC_SER_AW-1:0]     addr_sh_r;
    logic [7:0]                 dat_sh_r, out_sh_r;
    always_ff @(posedge ref_clk) begin
        if (!rst_n || cs_s2_r) begin
            ser_st_r    <= GCC_SER_IDLE;
            bit_cnt_r   <= '0;
            rd_r        <= 1'b0;
            addr_sh_r   <= '0;
            dat_sh_r    <= '0;
            host_wr_stb <= 1'b0;
            host_rd_stb <= 1'b0;
        end else begin
            host_wr_stb <= 1'b0;
            host_rd_stb <= 1'b0;
            case (ser_st_r)
                GCC_SER_IDLE: begin
                    if (cs_fall) begin
                        ser_st_r  <= GCC_SER_ADDR;
                        bit_cnt_r <= '0;
                    end
                end
                GCC_SER_ADDR: begin
                    if (sck_rise) begin
                        bit_cnt_r <= bit_cnt_r + 5'h1;
                        if (bit_cnt_r == 5'h0) begin
                            rd_r <= sdi_s2_r;
                        end else begin
                            addr_sh_r <= {addr_sh_r[`GCC_SER_AW-2:0], sdi_s2_r};
                        end
                        if (bit_cnt_r == 5'(`GCC_SER_AW)) begin
                            ser_st_r    <= GCC_SER_DATA;
                            host_rd_stb <= rd_r;
                        end
                    end
                end
                GCC_SER_DATA: begin
                    if (sck_rise) begin
                        bit_cnt_r <= bit_cnt_r + 5'h1;
                        dat_sh_r  <= {dat_sh_r[6:0], sdi_s2_r};
                        if (bit_cnt_r == 5'(`GCC_SER_FRAME - 1)) begin
                            ser_st_r    <= GCC_SER_IDLE;
                            host_wr_stb <= ~rd_r;
                        end
                    end
                end
                default: ser_st_r <= GCC_SER_IDLE;
            endcase
        end
    end

    // address and write data to the register side
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            host_addr  <= '0;
            host_wdata <= 8'h00;
        end else begin
            host_addr  <= addr_sh_r;
            host_wdata <= dat_sh_r;
        end
    end

    // read data shifts out on shift clock falling edges
    always_ff @(posedge ref_clk) begin
        if (!rst_n || cs_s2_r) begin
            out_sh_r        <= 8'h00;
            serial_out_pin  <= 1'b0;
            serial_out_oe_n <= 1'b1;
        end else begin
            if (host_rd_stb) begin
                out_sh_r <= host_rdata;
            end else if (ser_st_r == GCC_SER_DATA && rd_r && sck_fall) begin
                serial_out_pin  <= out_sh_r[7];
                serial_out_oe_n <= 1'b0;
                out_sh_r        <= {out_sh_r[6:0], 1'b0};
            end
        end
    end

endmodule
